// [rtl/spb_pkg.sv]
// package for the sector protection bit block
package spb_pkg;
  localparam int unsigned GROUPS       = 286;
  localparam int unsigned GRP_W        = 9;
  localparam int unsigned ADDR_W       = 24;
  localparam int unsigned BLK_LSB      = 16;
  localparam int unsigned SEC_LSB      = 12;
  localparam logic [7:0]  TOP_BLK_FIRST = 8'hFE;
  localparam logic [8:0]  TOP_GRP_BASE  = 9'h0FE;
  localparam logic [GROUPS-1:0] PERSIST_ERASED = {GROUPS{1'b1}};
  localparam logic [GROUPS-1:0] DYN_RESET      = {GROUPS{1'b1}};
  localparam logic        LOCK_OPEN    = 1'b1;
  localparam logic        LOCK_SHUT    = 1'b0;
  // nonvolatile cell program and erase times, in cycles of clk
  localparam int unsigned PROG_CYCLES  = 64;
  localparam int unsigned ERASE_CYCLES = 256;
  localparam int unsigned CNT_W        = 16;

  typedef enum logic [2:0] {
    SPB_CMD_NONE       = 3'h0,
    SPB_CMD_PROG_PERS  = 3'h1,
    SPB_CMD_ERASE_PERS = 3'h2,
    SPB_CMD_READ_PERS  = 3'h3,
    SPB_CMD_WRITE_DYN  = 3'h4,
    SPB_CMD_LOCK_CLEAR = 3'h5,
    SPB_CMD_UNLOCK     = 3'h6,
    SPB_CMD_READ_DYN   = 3'h7
  } spb_cmd_e;

  typedef enum logic [1:0] {
    SPB_IDLE  = 2'h0,
    SPB_PREP  = 2'h1,
    SPB_BUSY  = 2'h2
  } spb_state_e;

  typedef struct packed {
    spb_cmd_e            cmd;
    logic [ADDR_W-1:0]   addr;
    logic                dynValue;
    logic                pwdMatch;
  } spb_req_s;

  typedef struct packed {
    logic busy;
    logic progErr;
    logic protErr;
    logic persLock;
  } spb_stat_s;
endpackage

// [rtl/spb_sector_protection_bits.sv]
// sector protection bit store, lock control and address to group mapping
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - blocks 0..253 one group each; sectors of blocks 254,255 groups 254..285.
// - one persistent bit per group, programmed singly to 0, erased together to 1.
// - persistent erase ignores any address given with the command.
// - erase preprograms all bits itself before erasing, no host supervision.
// - busy status is shown during persistent program or erase.
// - array reads are refused while a persistent bit is programmed.
// - a persistent read command returns the persistent bit of the addressed group.
// - persistent bits start erased, value 1, unprotected.
// - dynamic bit per group written to 0 or 1 at will.
// - dynamic bit only matters when the persistent bit is 1.
// - one lock bit; 0 freezes persistent bits, 1 allows change.
// - with lock at 0, persistent program or erase fails, bits unchanged.
// - persistent mode sets lock to 1 on the first clock after hardware reset; reset itself loads 0.
// - persistent mode has no command setting lock back to 1.
// - password mode clears lock at reset; only a good unlock sets it.
// - program or erase blocked when either group bit is 0.
// - lock clear command writes the lock bit to 0.
// - lock management mode is fixed by one-time mode bits; here the passwordMode input, caught once after each hardware reset.
// - bad password sets program and protection error; lock stays 0.
module spb_sector_protection_bits (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            swReset,
  input  wire logic            passwordMode,
  input  wire logic            reqValid,
  input  wire spb_pkg::spb_req_s req,
  input  wire logic [spb_pkg::ADDR_W-1:0] arrayAddr,
  input  wire logic            errClear,
  output logic                 reqReady,
  output logic                 readData,
  output logic                 readValid,
  output logic                 cmdFail,
  output logic                 arrayWriteOk,
  output logic                 arrayReadOk,
  output spb_pkg::spb_stat_s   status
);
  import spb_pkg::*;

  // group number from an address, top boot layout
  function automatic logic [GRP_W-1:0] grpOf(input logic [ADDR_W-1:0] a);
    logic [7:0] blk;
    blk = a[ADDR_W-1:BLK_LSB];
    if (blk >= TOP_BLK_FIRST) begin
      grpOf = TOP_GRP_BASE + GRP_W'({blk[0], a[BLK_LSB-1:SEC_LSB]});
    end else begin
      grpOf = GRP_W'(blk);
    end
  endfunction

  logic [GROUPS-1:0] pers_ff, nxt_pers;
  logic [GROUPS-1:0] dyn_ff, nxt_dyn;
  logic              lock_ff, nxt_lock;
  logic              modeCap_ff, nxt_modeCap;
  logic              capDone_ff, nxt_capDone;
  spb_state_e        state_ff, nxt_state;
  logic [CNT_W-1:0]  cnt_ff, nxt_cnt;
  logic              isErase_ff, nxt_isErase;
  logic [GRP_W-1:0]  tgt_ff, nxt_tgt;
  logic              progErr_ff, nxt_progErr;
  logic              protErr_ff, nxt_protErr;
  logic              rdData_ff, nxt_rdData;
  logic              rdValid_ff, nxt_rdValid;
  logic              fail_ff, nxt_fail;
  logic [GRP_W-1:0]  reqGrp;
  logic [GRP_W-1:0]  arrGrp;
  logic              take;

  assign reqGrp = grpOf(req.addr);
  assign arrGrp = grpOf(arrayAddr);
  assign take   = reqValid && (state_ff == SPB_IDLE);

  // command, lock and bit update; the mode is caught once after reset so a
  // strap pin changing later cannot flip lock management
  always_comb begin
    nxt_pers    = pers_ff;
    nxt_dyn     = dyn_ff;
    nxt_lock    = lock_ff;
    nxt_modeCap = modeCap_ff;
    nxt_capDone = 1'b1;
    nxt_state   = state_ff;
    nxt_cnt     = cnt_ff;
    nxt_isErase = isErase_ff;
    nxt_tgt     = tgt_ff;
    nxt_progErr = progErr_ff;
    nxt_protErr = protErr_ff;
    nxt_rdData  = rdData_ff;
    nxt_rdValid = 1'b0;
    nxt_fail    = 1'b0;
    if (errClear) begin
      nxt_progErr = 1'b0;
      nxt_protErr = 1'b0;
    end
    if (!capDone_ff) begin
      nxt_modeCap = passwordMode;
      nxt_lock    = passwordMode ? LOCK_SHUT : LOCK_OPEN;
    end
    case (state_ff)
      SPB_IDLE: begin
        if (take && capDone_ff) begin
          case (req.cmd)
            SPB_CMD_PROG_PERS, SPB_CMD_ERASE_PERS: begin
              if (lock_ff == LOCK_SHUT) begin
                nxt_fail = 1'b1;
              end else begin
                nxt_isErase = (req.cmd == SPB_CMD_ERASE_PERS);
                nxt_tgt     = reqGrp; // ignored by erase
                nxt_cnt     = CNT_W'(PROG_CYCLES);
                nxt_state   = (req.cmd == SPB_CMD_ERASE_PERS) ? SPB_PREP : SPB_BUSY;
              end
            end
            SPB_CMD_READ_PERS: begin
              nxt_rdData  = pers_ff[reqGrp];
              nxt_rdValid = 1'b1;
            end
            SPB_CMD_READ_DYN: begin
              nxt_rdData  = dyn_ff[reqGrp];
              nxt_rdValid = 1'b1;
            end
            SPB_CMD_WRITE_DYN: begin
              nxt_dyn[reqGrp] = req.dynValue;
            end
            SPB_CMD_LOCK_CLEAR: begin
              nxt_lock = LOCK_SHUT;
            end
            SPB_CMD_UNLOCK: begin
              // persistent mode offers no way back to open
              if (modeCap_ff && req.pwdMatch && lock_ff == LOCK_SHUT) begin
                nxt_lock = LOCK_OPEN;
              end else if (modeCap_ff && !req.pwdMatch) begin
                nxt_progErr = 1'b1;
                nxt_protErr = 1'b1;
                nxt_fail    = 1'b1;
              end else begin
                nxt_fail = !modeCap_ff;
              end
            end
            default: begin
            end
          endcase
        end
      end
      SPB_PREP: begin
        // preprogram every bit to 0 before the bulk erase
        if (cnt_ff == CNT_W'(1)) begin
          nxt_pers  = '0;
          nxt_cnt   = CNT_W'(ERASE_CYCLES);
          nxt_state = SPB_BUSY;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      SPB_BUSY: begin
        if (cnt_ff == CNT_W'(1)) begin
          if (isErase_ff) begin
            nxt_pers = PERSIST_ERASED;
          end else begin
            nxt_pers[tgt_ff] = 1'b0;
          end
          nxt_state = SPB_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      default: begin
        nxt_state = SPB_IDLE;
      end
    endcase
    if (swReset) begin
      nxt_dyn = DYN_RESET;
    end
  end

  // registers; persistent bits come up erased as they would from the factory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pers_ff    <= PERSIST_ERASED;
      dyn_ff     <= DYN_RESET;
      lock_ff    <= LOCK_SHUT;
      modeCap_ff <= 1'b0;
      capDone_ff <= 1'b0;
      state_ff   <= SPB_IDLE;
      cnt_ff     <= '0;
      isErase_ff <= 1'b0;
      tgt_ff     <= '0;
      progErr_ff <= 1'b0;
      protErr_ff <= 1'b0;
      rdData_ff  <= 1'b0;
      rdValid_ff <= 1'b0;
      fail_ff    <= 1'b0;
    end else begin
      pers_ff    <= nxt_pers;
      dyn_ff     <= nxt_dyn;
      lock_ff    <= nxt_lock;
      modeCap_ff <= nxt_modeCap;
      capDone_ff <= nxt_capDone;
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      isErase_ff <= nxt_isErase;
      tgt_ff     <= nxt_tgt;
      progErr_ff <= nxt_progErr;
      protErr_ff <= nxt_protErr;
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
      fail_ff    <= nxt_fail;
    end
  end

  // outputs
  assign reqReady     = (state_ff == SPB_IDLE) && capDone_ff;
  assign readData     = rdData_ff;
  assign readValid    = rdValid_ff;
  assign cmdFail      = fail_ff;
  assign arrayWriteOk = pers_ff[arrGrp] && dyn_ff[arrGrp];
  assign arrayReadOk  = (state_ff == SPB_IDLE);
  assign status.busy     = (state_ff != SPB_IDLE);
  assign status.progErr  = progErr_ff;
  assign status.protErr  = protErr_ff;
  assign status.persLock = lock_ff;
endmodule // spb_sector_protection_bits

`default_nettype wire

// [test/spb_checker.sv]
// assertion checker for the sector protection bit block
`timescale 1ns/10ps
`default_nettype none
module spb_checker
  import spb_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               passwordMode,
  input wire logic               reqValid,
  input wire spb_pkg::spb_req_s  req,
  input wire logic               reqReady,
  input wire logic               readValid,
  input wire logic               cmdFail,
  input wire logic               arrayReadOk,
  input wire spb_pkg::spb_stat_s status
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a request counts only on the edge where both handshake sides agree
  wire logic took = reqValid && reqReady;
  wire logic pgEr = took && (req.cmd == SPB_CMD_PROG_PERS || req.cmd == SPB_CMD_ERASE_PERS);
  wire logic unl  = took && (req.cmd == SPB_CMD_UNLOCK);

  no_array_read_a: assert property (status.busy |-> !arrayReadOk) else $error("read while busy");
  busy_span_a: assert property (pgEr && status.persLock |=> status.busy[*8]) else $error("busy short");
  busy_refuse_a: assert property (status.busy |-> !reqReady) else $error("taken while busy");
  read_answer_a: assert property (took && req.cmd == SPB_CMD_READ_PERS |=> readValid && !cmdFail)
    else $error("no read answer");
  locked_fail_a: assert property (pgEr && !status.persLock |=> cmdFail && !status.busy)
    else $error("locked op ran");
  lock_keep_a: assert property (reqReady && !status.persLock && !(unl && passwordMode && req.pwdMatch)
    |=> !status.persLock) else $error("lock reopened");
  lock_clear_a: assert property (took && req.cmd == SPB_CMD_LOCK_CLEAR |=> !status.persLock)
    else $error("lock not cleared");
  bad_pwd_a: assert property (unl && passwordMode && !req.pwdMatch
    |=> status.progErr && status.protErr && !status.persLock) else $error("bad password");
  mode_fixed_a: assert property (unl && !passwordMode |=> cmdFail && $stable(status.persLock))
    else $error("unlock in persistent mode");
endmodule // spb_checker

bind spb_sector_protection_bits spb_checker spb_checker_i (.clk, .rst, .passwordMode, .reqValid,
  .req, .reqReady, .readValid, .cmdFail, .arrayReadOk, .status);
`default_nettype wire

// [test/spb_host_model.sv]
// host controller model that presents protection commands one at a time
`timescale 1ns/10ps
`default_nettype none
module spb_host_model
  import spb_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       go,
  input  wire spb_pkg::spb_cmd_e          cmdIn,
  input  wire logic [spb_pkg::ADDR_W-1:0] addrIn,
  input  wire logic                       dynIn,
  input  wire logic                       pwdIn,
  input  wire logic                       reqReady,
  output logic                            reqValid,
  output spb_pkg::spb_req_s               req,
  output logic                            done
);
  // note the edge that took the request so it is released only afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) done <= 1'b0;
    else done <= reqValid && reqReady;
  end
  // request held from a falling edge until the device has taken it
  always_ff @(negedge clk or posedge rst) begin
    if (rst) begin
      reqValid <= 1'b0;
      req      <= '0;
    end else if (reqValid && done) begin
      reqValid <= 1'b0;
      req      <= spb_req_s'(~req); // released lines never keep the old value
    end else if (go && !reqValid) begin
      reqValid     <= 1'b1;
      req.cmd      <= cmdIn;
      // reads carry the group's first address: sector base on top blocks, block base elsewhere
      if (cmdIn[1:0] == 2'b11) begin
        req.addr <= (addrIn[23:17] == 7'h7F) ? {addrIn[23:12], 12'h000}
                                             : {addrIn[23:16], 16'h0000};
      end else begin
        req.addr <= addrIn;
      end
      req.dynValue <= dynIn;
      req.pwdMatch <= pwdIn;
    end
  end
endmodule // spb_host_model
`default_nettype wire

// [test/testbench.sv]
// self-checking testbench for the sector protection bit block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import spb_pkg::*;
  logic clk = 0, rst = 1, swReset = 0, pm = 0, go = 0, errClear = 0, pwd = 0, dv = 0;
  logic reqValid, reqReady, readData, readValid, cmdFail, wOk, rOk, done;
  // one-cycle answer pulses caught while a command is in flight
  logic sawFail = 1'b0, sawRv = 1'b0;
  logic [ADDR_W-1:0] aA = '0, ad = '0;
  spb_cmd_e cm = SPB_CMD_NONE;
  spb_req_s req;
  spb_stat_s st;
  int failures = 0, n_tests = 0;

  spb_sector_protection_bits spb_sector_protection_bits_i (.clk, .rst, .swReset,
    .passwordMode(pm), .reqValid, .req, .arrayAddr(aA), .errClear, .reqReady, .readData,
    .readValid, .cmdFail, .arrayWriteOk(wOk), .arrayReadOk(rOk), .status(st));
  spb_host_model spb_host_model_i (.clk, .rst, .go, .cmdIn(cm), .addrIn(ad), .dynIn(dv),
    .pwdIn(pwd), .reqReady, .reqValid, .req, .done);

  // 200 MHz clock and a watchdog sized well beyond the longest erase
  initial forever #2.5 clk = ~clk;
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    final_report;
  end

  task automatic chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic hw(input logic m);
    pm  <= m;
    rst <= 1'b1;
    repeat (16) @(negedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  // one command through the host model; busy operations simply delay the take
  task automatic run(input spb_cmd_e c, input logic [23:0] a, input logic d, input logic p);
    int k;
    k = 0;
    sawFail = 1'b0;
    sawRv = 1'b0;
    cm <= c;
    ad <= a;
    dv <= d;
    pwd <= p;
    go <= 1'b1;
    do begin
      @(negedge clk);
      k++;
      sawFail = sawFail | cmdFail;
      sawRv = sawRv | readValid;
    end while (!done && k < 400);
    // a request never taken is a hang, not a silent pass
    if (!done) begin
      failures++;
      $display("[ERR] requestTaken expected 1 seen 0");
    end
    go <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input spb_cmd_e c, input logic [23:0] a, input logic e);
    run(c, a, 1'b0, 1'b0);
    chk("readData", e, readData);
    chk("readValid", 1'b1, sawRv);
  endtask
  task automatic wk(input logic [23:0] a, input logic e);
    aA <= a;
    @(negedge clk);
    chk("arrayWriteOk", e, wOk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // map, program, erase and dynamic bits in persistent mode, then password mode
  initial begin
    hw(1'b0);
    chk("persLock", 1'b1, st.persLock);
    rd(SPB_CMD_READ_PERS, 24'h000000, 1'b1);
    rd(SPB_CMD_READ_DYN, 24'h000000, 1'b1);
    run(SPB_CMD_PROG_PERS, 24'hFF3000, 1'b0, 1'b0);
    chk("cmdFail", 1'b0, sawFail);
    rd(SPB_CMD_READ_PERS, 24'hFF3000, 1'b0);
    rd(SPB_CMD_READ_PERS, 24'hFF2000, 1'b1);
    rd(SPB_CMD_READ_PERS, 24'hFE3000, 1'b1);
    rd(SPB_CMD_READ_PERS, 24'hFD0000, 1'b1);
    wk(24'hFF3ABC, 1'b0);
    wk(24'hFF4000, 1'b1);
    run(SPB_CMD_WRITE_DYN, 24'h050000, 1'b0, 1'b0);
    wk(24'h05FFFF, 1'b0);
    run(SPB_CMD_WRITE_DYN, 24'hFF3000, 1'b1, 1'b0);
    wk(24'hFF3000, 1'b0);
    run(SPB_CMD_ERASE_PERS, 24'h123000, 1'b0, 1'b0);
    // some 100 cycles into the erase, past the 64-cycle preprogram phase, every bit has been driven to 0
    repeat (100) @(negedge clk);
    wk(24'hFF2000, 1'b0);
    chk("busy", 1'b1, st.busy);
    chk("arrayReadOk", 1'b0, rOk);
    rd(SPB_CMD_READ_PERS, 24'hFF3000, 1'b1);
    chk("arrayReadOk", 1'b1, rOk);
    chk("busy", 1'b0, st.busy);
    wk(24'hFF3000, 1'b1);
    swReset <= 1'b1;
    @(negedge clk);
    swReset <= 1'b0;
    wk(24'h05FFFF, 1'b1);
    chk("persLock", 1'b1, st.persLock);
    $display("test map and bits done");
    run(SPB_CMD_LOCK_CLEAR, 24'h000000, 1'b0, 1'b0);
    chk("persLock", 1'b0, st.persLock);
    run(SPB_CMD_PROG_PERS, 24'h000000, 1'b0, 1'b0);
    chk("cmdFail", 1'b1, sawFail);
    rd(SPB_CMD_READ_PERS, 24'h000000, 1'b1);
    run(SPB_CMD_UNLOCK, 24'h000000, 1'b0, 1'b1);
    chk("cmdFail", 1'b1, sawFail);
    chk("persLock", 1'b0, st.persLock);
    $display("test persistent lock done");
    hw(1'b1);
    chk("persLock", 1'b0, st.persLock);
    run(SPB_CMD_UNLOCK, 24'h000000, 1'b0, 1'b0);
    chk("cmdFail", 1'b1, sawFail);
    chk("progErr", 1'b1, st.progErr);
    chk("protErr", 1'b1, st.protErr);
    chk("persLock", 1'b0, st.persLock);
    errClear <= 1'b1;
    @(negedge clk);
    errClear <= 1'b0;
    chk("progErr", 1'b0, st.progErr);
    run(SPB_CMD_UNLOCK, 24'h000000, 1'b0, 1'b1);
    chk("cmdFail", 1'b0, sawFail);
    chk("persLock", 1'b1, st.persLock);
    $display("test password lock done");
    final_report;
  end
endmodule // testbench
`default_nettype wire
